// ==== rtl/rcr_top.sv ====
`timescale 1ns/100ps
module rcr_top
    import rcr_pkg::*;
#(
    parameter bit DDR_VARIANT = 1'b0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Serial port pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Regulator pins and analog status
    input wire logic aux_linear_regulator_enable_pin,
    input wire logic aux_linear_regulator_out_low,
    input wire logic [NUM_BUCK-1:0] buck_enable_pin,
    input wire logic [NUM_BUCK-1:0] buck_out_low,
    input wire logic standby,
    // Aux linear regulator controls
    output logic aux_linear_regulator_on,
    output logic [1:0] aux_linear_regulator_vsel,
    // Step-down controls
    output logic [NUM_BUCK-1:0] buck_on,
    output logic [2*NUM_BUCK-1:0] buck_mode,
    output logic [5*NUM_BUCK-1:0] buck_reference_code,
    output logic [NUM_BUCK-1:0] buck_freq_low,
    output logic [NUM_BUCK-1:0] buck_phase2,
    output logic [NUM_BUCK-1:0] buck_fast_slew
);

    localparam int NPIN = 4 + 2 * NUM_BUCK;
    localparam logic [6:0] MY_ADDR = DDR_VARIANT ? DEV_ADDR_DDR : DEV_ADDR_BASE;

    function automatic logic [7:0] ctrl_reset(input int idx);
        return (DDR_VARIANT && idx == 0) ? BK1_CTRL_RST_DDR : BK_CTRL_RST;
    endfunction

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    logic [NPIN-1:0] s1_q, s2_q, s3_q, filt_q, filt_d, pins;
    assign pins = {buck_out_low, buck_enable_pin, aux_linear_regulator_out_low, aux_linear_regulator_enable_pin, sda_in, scl_in};

    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
        end
    end

    always_ff @(posedge mclk) begin
        s1_q <= pins;
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (sys_rst) begin
            filt_q <= {{(NPIN-2){1'b0}}, 2'h3};
        end else begin
            filt_q <= filt_d;
        end
    end

    logic scl_f, sda_f, scl_prev_q, sda_prev_q;
    logic ldo_pin_f, ldo_low_f;
    logic [NUM_BUCK-1:0] bk_pin_f, bk_low_f;
    assign scl_f = filt_q[0];
    assign sda_f = filt_q[1];
    assign ldo_pin_f = filt_q[2];
    assign ldo_low_f = filt_q[3];
    assign bk_pin_f = filt_q[4 +: NUM_BUCK];
    assign bk_low_f = filt_q[4 + NUM_BUCK +: NUM_BUCK];

    // --------------------------------------------------------------
    // Serial register port
    // --------------------------------------------------------------
    rcr_state_type st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
    logic oe_q, oe_d, rw_q, rw_d, wr_en;
    logic [7:0] ctrl_q [NUM_BUCK];
    logic [4:0] ref_q [NUM_BUCK];
    logic [7:0] ldo_q;
    logic [7:0] rd_byte;
    logic sda_out_q;
    logic scl_rise, scl_fall, start_cond, stop_cond;

    assign scl_rise = scl_f && !scl_prev_q;
    assign scl_fall = !scl_f && scl_prev_q;
    assign start_cond = scl_f && scl_prev_q && !sda_f && sda_prev_q;
    assign stop_cond = scl_f && scl_prev_q && sda_f && !sda_prev_q;

    function automatic logic [7:0] reg_read(input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < NUM_BUCK; i++) begin
            if (a == OFS_CONTROL_A + 8'(i)) r = ctrl_q[i];
            if (a == OFS_REF_CODE_A + 8'(i)) r = {3'h0, ref_q[i]};
        end
        if (a == OFS_AUX_LINEAR_REGULATOR_CONTROL) r = ldo_q;
        return r;
    endfunction

    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        oe_d = oe_q;
        rw_d = rw_q;
        wr_en = 1'b0;
        rd_byte = reg_read(ptr_q);
        if (start_cond) begin
            st_d = ST_ADDR;
            bit_d = 4'h0;
            oe_d = 1'b0;
        end else if (stop_cond) begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
        end else if (scl_rise) begin
            if (st_q == ST_RDATA && bit_q == 4'h8) begin
                if (sda_f) begin
                    st_d = ST_IDLE;
                end else begin
                    bit_d = 4'h0;
                    ptr_d = ptr_q + 8'h01;
                    sh_d = reg_read(ptr_q + 8'h01);
                end
            end else if (st_q == ST_ADDR || st_q == ST_PTR || st_q == ST_WDATA) begin
                sh_d = {sh_q[6:0], sda_f};
                bit_d = bit_q + 4'h1;
            end else if (st_q == ST_RDATA) begin
                bit_d = bit_q + 4'h1;
            end
        end else if (scl_fall) begin
            case (st_q)
                ST_ADDR: begin
                    if (bit_q == 4'h8) begin
                        if (sh_q[7:1] == MY_ADDR) begin
                            st_d = ST_AACK;
                            oe_d = 1'b1;
                            rw_d = sh_q[0];
                        end else begin
                            st_d = ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    bit_d = 4'h0;
                    if (rw_q) begin
                        st_d = ST_RDATA;
                        oe_d = ~rd_byte[7];
                        sh_d = {rd_byte[6:0], 1'b0};
                    end else begin
                        st_d = ST_PTR;
                        oe_d = 1'b0;
                    end
                end
                ST_PTR: begin
                    if (bit_q == 4'h8) begin
                        st_d = ST_PACK;
                        ptr_d = sh_q;
                        oe_d = 1'b1;
                    end
                end
                ST_WDATA: begin
                    if (bit_q == 4'h8) begin
                        st_d = ST_WACK;
                        wr_en = 1'b1;
                        ptr_d = ptr_q + 8'h01;
                        oe_d = 1'b1;
                    end
                end
                ST_PACK, ST_WACK: begin
                    st_d = ST_WDATA;
                    bit_d = 4'h0;
                    oe_d = 1'b0;
                end
                ST_RDATA: begin
                    if (bit_q == 4'h8) begin
                        oe_d = 1'b0;
                    end else begin
                        oe_d = ~sh_q[7];
                        sh_d = {sh_q[6:0], 1'b0};
                    end
                end
                default: begin
                    st_d = ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
            sda_out_q <= 1'b0;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            oe_q <= 1'b0;
            rw_q <= 1'b0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            st_q <= st_d;
            sda_out_q <= 1'b0;
            bit_q <= bit_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            oe_q <= oe_d;
            rw_q <= rw_d;
            scl_prev_q <= scl_f;
            sda_prev_q <= sda_f;
        end
    end

    assign sda_oe = oe_q;
    assign sda_out = sda_out_q;

    // --------------------------------------------------------------
    // Aux linear regulator
    // --------------------------------------------------------------
    logic [7:0] ldo_d;
    logic ldo_on_q, ldo_on_d, ldo_req;

    always_comb begin
        ldo_d = ldo_q;
        if (wr_en && ptr_q == OFS_AUX_LINEAR_REGULATOR_CONTROL) begin
            ldo_d = sh_q & AUX_LINEAR_REGULATOR_CTRL_MASK;
        end
        // Base variant ORs in the pin; the DDR part has the pin but ignores it.
        ldo_req = ldo_q[LD_ENABLE] || (!DDR_VARIANT && ldo_pin_f);
        if (!ldo_req || (standby && !ldo_q[LD_KEEP_STBY])) begin
            ldo_on_d = 1'b0;
        end else if (ldo_on_q) begin
            ldo_on_d = 1'b1;
        end else begin
            ldo_on_d = !ldo_q[LD_START_LOW] || ldo_low_f;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ldo_q <= AUX_LINEAR_REGULATOR_CTRL_RST;
            ldo_on_q <= 1'b0;
        end else begin
            ldo_q <= ldo_d;
            ldo_on_q <= ldo_on_d;
        end
    end

    assign aux_linear_regulator_on = ldo_on_q;
    assign aux_linear_regulator_vsel = ldo_q[LD_VSEL_LSB +: 2];

    // --------------------------------------------------------------
    // Step-down regulators
    // --------------------------------------------------------------
    for (genvar g = 0; g < NUM_BUCK; g++) begin : g_buck
        logic [7:0] ctrl_d;
        logic [4:0] ref_d;
        logic on_q, on_d, req, freq_q;

        always_comb begin
            ctrl_d = ctrl_q[g];
            ref_d = ref_q[g];
            if (wr_en && ptr_q == OFS_CONTROL_A + 8'(g)) begin
                ctrl_d = sh_q;
                if (sh_q[BK_MODE_LSB +: 2] == MODE_INVALID) begin
                    ctrl_d[BK_MODE_LSB +: 2] = ctrl_q[g][BK_MODE_LSB +: 2];
                end
            end
            if (wr_en && ptr_q == OFS_REF_CODE_A + 8'(g)) begin
                ref_d = sh_q[4:0];
            end
            req = bk_pin_f[g] || ctrl_q[g][BK_FORCE_ON];
            if (!req || (standby && !ctrl_q[g][BK_KEEP_STBY])) begin
                on_d = 1'b0;
            end else if (on_q) begin
                on_d = 1'b1;
            end else begin
                on_d = !ctrl_q[g][BK_START_LOW] || bk_low_f[g];
            end
        end

        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                ctrl_q[g] <= ctrl_reset(g);
                ref_q[g] <= REF_CODE_RST;
                on_q <= 1'b0;
                freq_q <= DDR_VARIANT && g == 0;
            end else begin
                ctrl_q[g] <= ctrl_d;
                ref_q[g] <= ref_d;
                on_q <= on_d;
                // The DDR part reads the frequency bit of its first regulator with inverted sense.
                freq_q <= ctrl_d[BK_FREQ_ALT] ^ (DDR_VARIANT && g == 0);
            end
        end

        assign buck_on[g] = on_q;
        assign buck_mode[2*g +: 2] = ctrl_q[g][BK_MODE_LSB +: 2];
        assign buck_reference_code[5*g +: 5] = ref_q[g];
        assign buck_freq_low[g] = freq_q;
        assign buck_phase2[g] = ctrl_q[g][BK_PHASE2];
        assign buck_fast_slew[g] = ctrl_q[g][BK_FAST_SLEW];
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    property p_ldo_ddr_reg_only;
        @(posedge mclk) disable iff (sys_rst) (DDR_VARIANT && !ldo_q[LD_ENABLE]) |=> !aux_linear_regulator_on;
    endproperty
    a_ldo_ddr_reg_only: assert property (p_ldo_ddr_reg_only) else $error("aux on without enable bit");
    property p_ldo_pin_follow;
        @(posedge mclk) disable iff (sys_rst)
            (!DDR_VARIANT && !ldo_q[LD_ENABLE] && !ldo_pin_f) |=> !aux_linear_regulator_on;
    endproperty
    a_ldo_pin_follow: assert property (p_ldo_pin_follow) else $error("aux on with pin low");
    property p_ldo_standby;
        @(posedge mclk) disable iff (sys_rst) (standby && !ldo_q[LD_KEEP_STBY]) |=> !aux_linear_regulator_on;
    endproperty
    a_ldo_standby: assert property (p_ldo_standby) else $error("aux on in standby");
    property p_ldo_start_low;
        @(posedge mclk) disable iff (sys_rst) (!aux_linear_regulator_on && ldo_q[LD_START_LOW] && !ldo_low_f) |=> !aux_linear_regulator_on;
    endproperty
    a_ldo_start_low: assert property (p_ldo_start_low) else $error("aux started above threshold");
    property p_buck_force;
        @(posedge mclk) disable iff (sys_rst)
            (ctrl_q[0][BK_FORCE_ON] && !standby && !ctrl_q[0][BK_START_LOW]) [*2] |-> buck_on[0];
    endproperty
    a_buck_force: assert property (p_buck_force) else $error("forced step-down not on");
    property p_ref_reset;
        @(posedge mclk) $fell(sys_rst) |-> (buck_reference_code == {NUM_BUCK{REF_CODE_RST}});
    endproperty
    a_ref_reset: assert property (p_ref_reset) else $error("reference code reset wrong");
    property p_freq_reset;
        @(posedge mclk) $fell(sys_rst) |-> (buck_freq_low == {3'h0, DDR_VARIANT} && buck_fast_slew == 4'h0);
    endproperty
    a_freq_reset: assert property (p_freq_reset) else $error("frequency or slew reset wrong");
    property p_mode_legal;
        @(posedge mclk) disable iff (sys_rst) buck_mode[1:0] != MODE_INVALID;
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("illegal mode code");
    property p_ctrl_write;
        @(posedge mclk) disable iff (sys_rst)
            (wr_en && ptr_q == OFS_CONTROL_A) |=> (buck_fast_slew[0] == $past(sh_q[BK_FAST_SLEW])
                && buck_phase2[0] == $past(sh_q[BK_PHASE2]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write not applied");
    property p_hold;
        @(posedge mclk) disable iff (sys_rst) !wr_en |=> ($stable(buck_reference_code) && $stable(aux_linear_regulator_vsel));
    endproperty
    a_hold: assert property (p_hold) else $error("field changed without write");

endmodule

// ==== rtl/rcr_pkg.sv ====
package rcr_pkg;

    // --------------------------------------------------------------
    // Serial port
    // --------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR_BASE = 7'h3c;
    localparam logic [6:0] DEV_ADDR_DDR = 7'h3d;

    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL_A = 8'h01;
    localparam logic [7:0] OFS_AUX_LINEAR_REGULATOR_CONTROL = 8'h09;
    localparam logic [7:0] OFS_REF_CODE_A = 8'h0a;
    localparam int NUM_BUCK = 4;

    // --------------------------------------------------------------
    // Step-down control fields
    // --------------------------------------------------------------
    localparam int BK_FAST_SLEW = 0;
    localparam int BK_KEEP_STBY = 1;
    localparam int BK_FREQ_ALT = 2;
    localparam int BK_PHASE2 = 3;
    localparam int BK_START_LOW = 4;
    localparam int BK_MODE_LSB = 5;
    localparam int BK_FORCE_ON = 7;
    localparam logic [7:0] BK_CTRL_RST = 8'h00;
    localparam logic [7:0] BK1_CTRL_RST_DDR = 8'h40;
    localparam logic [1:0] MODE_PULSE_SKIP = 2'h0;
    localparam logic [1:0] MODE_BURST = 2'h1;
    localparam logic [1:0] MODE_FORCED_CONT = 2'h2;
    localparam logic [1:0] MODE_INVALID = 2'h3;

    // --------------------------------------------------------------
    // Reference DAC: mV = code * 12.5 + 412.5
    // --------------------------------------------------------------
    localparam logic [4:0] REF_CODE_RST = 5'h19;
    localparam int DAC_STEP_UV = 12500;
    localparam int DAC_BASE_UV = 412500;

    // --------------------------------------------------------------
    // Aux linear regulator control fields
    // --------------------------------------------------------------
    localparam int LD_KEEP_STBY = 0;
    localparam int LD_START_LOW = 1;
    localparam int LD_ENABLE = 2;
    localparam int LD_VSEL_LSB = 3;
    localparam logic [7:0] AUX_LINEAR_REGULATOR_CTRL_RST = 8'h00;
    localparam logic [7:0] AUX_LINEAR_REGULATOR_CTRL_MASK = 8'h1f;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_AACK = 8'h04,
        ST_PTR = 8'h08,
        ST_PACK = 8'h10,
        ST_WDATA = 8'h20,
        ST_WACK = 8'h40,
        ST_RDATA = 8'h80
    } rcr_state_type;

endpackage

// ==== sim/rcr_i2c_host.sv ====
`timescale 1ns/100ps
module rcr_i2c_host (
    // Clock
    input wire logic mclk,
    // Serial bus
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // ----------------------------------------
    // Bit timing
    // ----------------------------------------
    // The serial clock half period is ten system clocks and stands high between frames.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic put_bit(input logic b);
        sda_low = ~b;
        cyc(5);
        scl = 1'b1;
        cyc(10);
        scl = 1'b0;
        cyc(5);
    endtask

    task automatic get_bit(output logic b);
        sda_low = 1'b0;
        cyc(5);
        scl = 1'b1;
        cyc(5);
        b = sda;
        cyc(5);
        scl = 1'b0;
        cyc(5);
    endtask

    task automatic start_cond();
        sda_low = 1'b0;
        cyc(5);
        scl = 1'b1;
        cyc(5);
        sda_low = 1'b1;
        cyc(5);
        scl = 1'b0;
        cyc(5);
    endtask

    task automatic stop_cond();
        sda_low = 1'b1;
        cyc(5);
        scl = 1'b1;
        cyc(5);
        sda_low = 1'b0;
        cyc(10);
    endtask

    task automatic send(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(b);
        ack = ~b;
    endtask

    // ----------------------------------------
    // Register transfers
    // ----------------------------------------
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] data, output logic ack);
        logic a0;
        logic a1;
        logic a2;
        start_cond();
        send({dev, 1'b0}, a0);
        send(ofs, a1);
        send(data, a2);
        stop_cond();
        ack = a0 & a1 & a2;
    endtask

    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] data);
        logic a;
        start_cond();
        send({dev, 1'b0}, a);
        send(ofs, a);
        start_cond();
        send({dev, 1'b1}, a);
        for (int i = 7; i >= 0; i--) begin
            get_bit(data[i]);
        end
        put_bit(1'b1);
        stop_cond();
    endtask
endmodule

// ==== sim/rcr_top_tb.sv ====
`timescale 1ns/100ps
`define CHECK_EQ(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("mismatch at %0t got %h expected %h", $time, got, exp); \
    end \
end
module rcr_top_tb
    import rcr_pkg::*;
;
    typedef struct packed {
        logic ddr;
        logic [7:0] ofs;
        logic [7:0] wd;
        logic [7:0] rd;
        logic [2:0] sel;
        logic [19:0] oexp;
    } rcr_row_type;

    // Ordinary register cases, applied in order: device, offset, write, readback, output, expected output.
    localparam rcr_row_type ROWS [16] = '{
        '{1'b0, 8'h01, 8'h01, 8'h01, 3'h4, 20'h1}, '{1'b0, 8'h02, 8'h08, 8'h08, 3'h3, 20'h2},
        '{1'b0, 8'h03, 8'h04, 8'h04, 3'h2, 20'h4}, '{1'b0, 8'h04, 8'h20, 8'h20, 3'h0, 20'h40},
        '{1'b0, 8'h01, 8'h40, 8'h40, 3'h0, 20'h42}, '{1'b0, 8'h01, 8'h60, 8'h40, 3'h0, 20'h42},
        '{1'b0, 8'h02, 8'h40, 8'h40, 3'h0, 20'h4a}, '{1'b0, 8'h0a, 8'h00, 8'h00, 3'h1, 20'hce720},
        '{1'b0, 8'h0d, 8'hff, 8'h1f, 3'h1, 20'hfe720}, '{1'b0, 8'h07, 8'h55, 8'h00, 3'h1, 20'hfe720},
        '{1'b1, 8'h09, 8'h18, 8'h18, 3'h5, 20'h3}, '{1'b1, 8'h09, 8'h08, 8'h08, 3'h5, 20'h1},
        '{1'b1, 8'h09, 8'hf0, 8'h10, 3'h5, 20'h2}, '{1'b1, 8'h09, 8'h00, 8'h00, 3'h5, 20'h0},
        '{1'b1, 8'h01, 8'h04, 8'h04, 3'h6, 20'h0}, '{1'b1, 8'h01, 8'h00, 8'h00, 3'h6, 20'h1}
    };

    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic scl;
    logic host_sda_low;
    logic sda_line;
    logic aux_linear_regulator_enable_pin = 1'b0;
    logic aux_linear_regulator_out_low = 1'b0;
    logic [3:0] buck_enable_pin = 4'h0;
    logic [3:0] buck_out_low = 4'h0;
    logic standby = 1'b0;
    logic sda_out_v [2];
    logic sda_oe_v [2];
    logic ldo_on_v [2];
    logic [1:0] vsel_v [2];
    logic [3:0] on_v [2];
    logic [7:0] mode_v [2];
    logic [19:0] ref_v [2];
    logic [3:0] flow_v [2];
    logic [3:0] ph2_v [2];
    logic [3:0] fast_v [2];
    int error_cnt = 0;
    int compares = 0;
    logic ack;
    logic [7:0] rdat;

    always #50 mclk = ~mclk;

    // Both variants share one open-drain bus with a pull-up, at different addresses.
    assign sda_line = ~(host_sda_low | (sda_oe_v[0] & ~sda_out_v[0]) | (sda_oe_v[1] & ~sda_out_v[1]));

    rcr_i2c_host rcr_i2c_host_inst (.mclk(mclk), .scl(scl), .sda_low(host_sda_low), .sda(sda_line));

    for (genvar g = 0; g < 2; g++) begin : gen_dut
        rcr_top #(.DDR_VARIANT(g == 1)) rcr_top_inst (
            .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line),
            .sda_out(sda_out_v[g]), .sda_oe(sda_oe_v[g]), .aux_linear_regulator_enable_pin(aux_linear_regulator_enable_pin),
            .aux_linear_regulator_out_low(aux_linear_regulator_out_low), .buck_enable_pin(buck_enable_pin), .buck_out_low(buck_out_low),
            .standby(standby), .aux_linear_regulator_on(ldo_on_v[g]), .aux_linear_regulator_vsel(vsel_v[g]), .buck_on(on_v[g]),
            .buck_mode(mode_v[g]), .buck_reference_code(ref_v[g]), .buck_freq_low(flow_v[g]),
            .buck_phase2(ph2_v[g]), .buck_fast_slew(fast_v[g])
        );
    end

    function automatic logic [19:0] pick(input logic [2:0] sel);
        case (sel)
            3'h0: return 20'(mode_v[0]);
            3'h1: return ref_v[0];
            3'h2: return 20'(flow_v[0]);
            3'h3: return 20'(ph2_v[0]);
            3'h4: return 20'(fast_v[0]);
            3'h5: return 20'(vsel_v[1]);
            default: return 20'(flow_v[1]);
        endcase
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic wr(input logic ddr, input logic [7:0] ofs, input logic [7:0] d);
        rcr_i2c_host_inst.write_reg(ddr ? DEV_ADDR_DDR : DEV_ADDR_BASE, ofs, d, ack);
        `CHECK_EQ(ack, 1'b1)
    endtask

    task automatic test_done();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        test_done();
    end

    initial begin
        cyc(20);
        sys_rst = 1'b0;
        cyc(10);
        `CHECK_EQ({ref_v[0], ref_v[1]}, {8{REF_CODE_RST}})
        `CHECK_EQ({mode_v[0], mode_v[1], flow_v[0], flow_v[1]}, 24'h000201)
        `CHECK_EQ({ph2_v[0], fast_v[0], on_v[0], on_v[1]}, 16'h0)
        `CHECK_EQ({ldo_on_v[0], ldo_on_v[1], vsel_v[1]}, 4'h0)
        rcr_i2c_host_inst.read_reg(DEV_ADDR_BASE, OFS_AUX_LINEAR_REGULATOR_CONTROL, rdat);
        `CHECK_EQ(rdat, AUX_LINEAR_REGULATOR_CTRL_RST)
        rcr_i2c_host_inst.read_reg(DEV_ADDR_DDR, OFS_CONTROL_A, rdat);
        `CHECK_EQ(rdat, BK1_CTRL_RST_DDR)
        for (int i = 0; i < 16; i++) begin
            wr(ROWS[i].ddr, ROWS[i].ofs, ROWS[i].wd);
            rcr_i2c_host_inst.read_reg(ROWS[i].ddr ? DEV_ADDR_DDR : DEV_ADDR_BASE, ROWS[i].ofs, rdat);
            `CHECK_EQ(rdat, ROWS[i].rd)
            `CHECK_EQ(pick(ROWS[i].sel), ROWS[i].oexp)
        end
        rcr_i2c_host_inst.write_reg(7'h3e, OFS_CONTROL_A, 8'h80, ack);
        `CHECK_EQ({ack, on_v[0]}, 5'h0)
        buck_enable_pin = 4'h2;
        cyc(8);
        `CHECK_EQ(on_v[0], 4'h2)
        buck_enable_pin = 4'h0;
        cyc(8);
        `CHECK_EQ(on_v[0], 4'h0)
        wr(1'b0, OFS_CONTROL_A, 8'h80);
        cyc(2);
        `CHECK_EQ(on_v[0], 4'h1)
        wr(1'b0, 8'h02, 8'h90);
        cyc(8);
        `CHECK_EQ(on_v[0], 4'h1)
        buck_out_low = 4'h2;
        cyc(8);
        `CHECK_EQ(on_v[0], 4'h3)
        buck_out_low = 4'h0;
        cyc(8);
        `CHECK_EQ(on_v[0], 4'h3)
        standby = 1'b1;
        cyc(4);
        `CHECK_EQ(on_v[0], 4'h0)
        wr(1'b0, OFS_CONTROL_A, 8'h82);
        cyc(2);
        `CHECK_EQ(on_v[0], 4'h1)
        standby = 1'b0;
        aux_linear_regulator_enable_pin = 1'b1;
        cyc(8);
        `CHECK_EQ({ldo_on_v[0], ldo_on_v[1]}, 2'h2)
        aux_linear_regulator_enable_pin = 1'b0;
        cyc(8);
        `CHECK_EQ(ldo_on_v[0], 1'b0)
        wr(1'b0, OFS_AUX_LINEAR_REGULATOR_CONTROL, 8'h06);
        cyc(8);
        `CHECK_EQ(ldo_on_v[0], 1'b0)
        aux_linear_regulator_out_low = 1'b1;
        cyc(8);
        `CHECK_EQ(ldo_on_v[0], 1'b1)
        standby = 1'b1;
        cyc(4);
        `CHECK_EQ(ldo_on_v[0], 1'b0)
        wr(1'b0, OFS_AUX_LINEAR_REGULATOR_CONTROL, 8'h07);
        cyc(2);
        `CHECK_EQ(ldo_on_v[0], 1'b1)
        standby = 1'b0;
        wr(1'b1, OFS_AUX_LINEAR_REGULATOR_CONTROL, 8'h04);
        cyc(2);
        `CHECK_EQ(ldo_on_v[1], 1'b1)
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        cyc(10);
        `CHECK_EQ({ref_v[0], on_v[0], ldo_on_v[0], ldo_on_v[1]}, {{4{REF_CODE_RST}}, 6'h0})
        test_done();
    end
endmodule
